// file: ela_pkg.sv
// Shared types and constants for the endian lane alignment block.
// Assumes one bus clock domain; no software-visible registers.
package ela_pkg;

  typedef enum logic [1:0] {
    ELA_AREA_NORMAL = 2'h0,
    ELA_AREA_SDRAM = 2'h1,
    ELA_AREA_PCMCIA = 2'h2
  } ela_area_e;

  // Access size and device width as log2 of byte count
  localparam logic [1:0] ELA_LG_BYTE = 2'h0;
  localparam logic [1:0] ELA_LG_WORD = 2'h1;
  localparam logic [1:0] ELA_LG_LONG = 2'h2;

  localparam int ELA_LANES = 4;
  localparam int ELA_FIFO_DEPTH = 8;
  localparam logic ELA_ENDIAN_RESET = 1'b0;
  localparam logic [3:0] ELA_LANES_NONE = 4'h0;
  localparam logic [3:0] ELA_MASK_ALL = 4'hf;
  localparam logic [1:0] ELA_CYCLE_FIRST = 2'h0;
  localparam logic [2:0] ELA_SYNC_RESET = 3'h0;

  typedef struct packed {
    logic write;
    logic [1:0] size_lg;
    logic [1:0] width_lg;
    ela_area_e area;
    logic [1:0] addr;
    logic [31:0] wdata;
  } ela_req_s;

  localparam int ELA_REQ_W = $bits(ela_req_s);

  typedef struct packed {
    logic cycle;
    logic write;
    logic [1:0] addr;
    logic [3:0] write_strobe;
    logic [3:0] byte_mask;
    logic [3:0] data_oe;
    logic [31:0] data;
  } ela_bus_s;

  localparam ela_bus_s ELA_BUS_IDLE = '{
    cycle: 1'b0, write: 1'b0, addr: 2'h0, write_strobe: 4'h0,
    byte_mask: 4'hf, data_oe: 4'h0, data: 32'h0
  };

  typedef enum logic [3:0] {
    ELA_ST_IDLE = 4'h1,
    ELA_ST_DRIVE = 4'h2,
    ELA_ST_RELEASE = 4'h4,
    ELA_ST_SPARE = 4'h8
  } ela_state_e;

endpackage

// file: ela_lane_align.sv
// Request FIFO and byte-lane alignment sequencer for the external bus.
// Assumes requests from logic on i_mclk; pins come in asynchronously.
`timescale 1ns/100ps

module ela_fifo
  import ela_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic i_mclk,               // Bus clock
  input wire logic i_nrst,               // Async reset, active low
  input wire logic i_in_valid,           // Write side valid
  input wire logic [WIDTH-1:0] i_in_data, // Write side data
  output logic o_in_ready,               // Not full, registered
  output logic o_out_valid,              // Not empty
  output logic [WIDTH-1:0] o_out_data,   // Head entry
  input wire logic i_out_ready           // Drain side ready
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0] cnt_r, cnt_nxt;
  logic rdy_r, rdy_nxt;
  logic push, pop;

  always_comb begin
    push = i_in_valid && rdy_r;
    pop = i_out_ready && (cnt_r != '0);
    wp_nxt = push ? wp_r + 1'b1 : wp_r;
    rp_nxt = pop ? rp_r + 1'b1 : rp_r;
    cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    rdy_nxt = cnt_nxt != (AW+1)'(DEPTH);
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
      rdy_r <= 1'b0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
      rdy_r <= rdy_nxt;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (push) begin
      mem_r[wp_r] <= i_in_data;
    end
  end

  assign o_in_ready = rdy_r;
  assign o_out_valid = cnt_r != '0;
  assign o_out_data = mem_r[rp_r];
endmodule

// Notes on behaviour
// RQ1 - Big-endian puts byte address 0 at the datum's top byte, little at the bottom.
// RQ2 - Byte order is caught from the endian select pin after reset, low big, high little.
// RQ3 - Ordinary memory areas accept 8-, 16- and 32-bit device widths.
// RQ4 - Synchronous DRAM areas accept only 16- and 32-bit widths.
// RQ5 - PCMCIA areas accept only 8- and 16-bit widths.
// RQ6 - An access wider than the device is split into successive device cycles.
// RQ7 - On a 32-bit big-endian device a byte at offset 0..3 uses lane 3..0 only.
// RQ8 - On a 32-bit big-endian device words use lanes 3-2 or 1-0, a longword all.
// RQ9 - On a 16-bit big-endian device even bytes use lane 1, odd bytes lane 0.
// RQ10 - A 16-bit big-endian longword is two cycles, top half first, lanes 1-0.
// RQ11 - On an 8-bit big-endian device every byte uses lane 0 only.
// RQ12 - 8-bit big-endian words and longwords run byte by byte, top byte first.
// RQ13 - Lanes without valid data keep strobes off and their read data ignored.
// RQ14 - Lane strobes are write enables for ordinary memory, masks for DRAM.
module ela_lane_align
  import ela_pkg::*;
(
  input wire logic i_mclk,               // Bus clock, 25 MHz
  input wire logic i_nrst,               // Async reset, active low
  input wire logic i_req_valid,          // Request valid
  input wire ela_req_s i_req,            // Request fields
  output logic o_req_ready,              // Request FIFO has room
  output logic o_rsp_valid,              // One-cycle completion pulse
  output logic o_rsp_error,              // Illegal size, width, area or alignment
  output logic [31:0] o_rsp_rdata,       // Read datum, right-justified
  input wire logic i_endian_select_pin,  // Byte order strap
  output logic o_little_endian,          // Latched byte order
  output logic o_endian_ready,           // Byte order has been caught
  output logic o_bus_cycle,              // Device cycle active
  output logic o_bus_write,              // Cycle is a write
  output logic [1:0] o_bus_addr,         // Byte offset of the cycle
  output logic [3:0] o_lane_write_strobe, // Lane write enables, high on
  output logic [3:0] o_lane_byte_mask,   // Lane DRAM masks, high masks
  output logic [31:0] o_data_out,        // Data pins, output side
  output logic [3:0] o_data_oe,          // Data pin enables per lane
  input wire logic [31:0] i_data_in,     // Data pins, input side
  input wire logic i_bus_ack             // Device acknowledge
);
  logic fifo_valid, fifo_pop;
  ela_req_s hd;

  ela_fifo #(.WIDTH(ELA_REQ_W), .DEPTH(ELA_FIFO_DEPTH)) u_fifo (
    .i_mclk(i_mclk),
    .i_nrst(i_nrst),
    .i_in_valid(i_req_valid),
    .i_in_data(i_req),
    .o_in_ready(o_req_ready),
    .o_out_valid(fifo_valid),
    .o_out_data(hd),
    .i_out_ready(fifo_pop)
  );

  // Pin synchronisers
  logic [2:0] end_s_r, ack_s_r, fill_r;
  logic [31:0] din_s1_r, din_s2_r, din_s3_r;
  logic ack_hi, ack_lo, end_stable;

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      end_s_r <= ELA_SYNC_RESET;
      ack_s_r <= ELA_SYNC_RESET;
      fill_r <= ELA_SYNC_RESET;
      din_s1_r <= '0;
      din_s2_r <= '0;
      din_s3_r <= '0;
    end else begin
      end_s_r <= {end_s_r[1:0], i_endian_select_pin};
      ack_s_r <= {ack_s_r[1:0], i_bus_ack};
      // Marks stages that hold a real pin sample, not reset zeros
      fill_r <= {fill_r[1:0], 1'b1};
      din_s1_r <= i_data_in;
      din_s2_r <= din_s1_r;
      din_s3_r <= din_s2_r;
    end
  end

  always_comb begin
    ack_hi = ack_s_r[1] && ack_s_r[2];
    ack_lo = !ack_s_r[1] && !ack_s_r[2];
    end_stable = end_s_r[1] == end_s_r[2];
  end

  // Byte order strap capture
  logic le_r, le_nxt, endok_r, endok_nxt;

  always_comb begin
    le_nxt = le_r;
    endok_nxt = endok_r;
    if (!endok_r && fill_r[2] && end_stable) begin
      le_nxt = end_s_r[2]; // RQ2
      endok_nxt = 1'b1;
    end
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      le_r <= ELA_ENDIAN_RESET;
      endok_r <= 1'b0;
    end else begin
      le_r <= le_nxt;
      endok_r <= endok_nxt;
    end
  end

  // Lane mapping for the head request and the current cycle
  logic [1:0] k_r, k_nxt;
  logic [2:0] wb, sb;
  logic [1:0] ncyc_m1, cb;
  logic [3:0] lane_use;
  logic [1:0] lane_sel [ELA_LANES];
  logic illegal;

  always_comb begin
    wb = 3'h1 << hd.width_lg;
    sb = 3'h1 << hd.size_lg;
    ncyc_m1 = 2'h0;
    if (hd.size_lg > hd.width_lg) begin
      ncyc_m1 = 2'((3'h1 << (hd.size_lg - hd.width_lg)) - 3'h1); // RQ6
    end
    cb = (hd.addr & ~(wb[1:0] - 2'h1)) + 2'(k_r << hd.width_lg);
    illegal = (hd.size_lg > ELA_LG_LONG) || (hd.width_lg > ELA_LG_LONG)
      || ((hd.addr & (sb[1:0] - 2'h1)) != 2'h0);
    unique case (hd.area)
      ELA_AREA_NORMAL: illegal = illegal; // RQ3
      ELA_AREA_SDRAM: illegal = illegal || hd.width_lg == ELA_LG_BYTE; // RQ4
      ELA_AREA_PCMCIA: illegal = illegal || hd.width_lg == ELA_LG_LONG; // RQ5
      default: illegal = 1'b1;
    endcase
  end

  for (genvar l = 0; l < ELA_LANES; l++) begin : g_lane
    logic [2:0] off, ba, idx;
    always_comb begin
      off = le_r ? 3'(l) : wb - 3'h1 - 3'(l); // RQ1 RQ7 RQ9 RQ11
      ba = {1'b0, cb} + off;
      idx = ba - {1'b0, hd.addr};
      lane_use[l] = (3'(l) < wb) && (ba >= {1'b0, hd.addr}) && (idx < sb);
      lane_sel[l] = le_r ? idx[1:0] : 2'(sb - 3'h1 - idx); // RQ8 RQ10 RQ12
    end
  end

  // Sequencer
  ela_state_e st_r, st_nxt;
  ela_bus_s bus_r, bus_nxt, bus_drv;
  logic [31:0] acc_r, acc_nxt, rdata_r, rdata_nxt;
  logic rv_r, rv_nxt, re_r, re_nxt;

  always_comb begin
    bus_drv = ELA_BUS_IDLE;
    bus_drv.cycle = 1'b1;
    bus_drv.write = hd.write;
    bus_drv.addr = cb;
    for (int l = 0; l < ELA_LANES; l++) begin
      if (lane_use[l] && hd.write) begin
        bus_drv.data[8*l +: 8] = hd.wdata[8*lane_sel[l] +: 8];
        bus_drv.data_oe[l] = 1'b1;
      end
    end
    if (hd.area == ELA_AREA_SDRAM) begin
      bus_drv.byte_mask = ~lane_use; // RQ14 RQ13
    end else if (hd.write) begin
      bus_drv.write_strobe = lane_use; // RQ14 RQ13
    end
  end

  always_comb begin
    st_nxt = st_r;
    bus_nxt = bus_r;
    k_nxt = k_r;
    acc_nxt = acc_r;
    rdata_nxt = rdata_r;
    rv_nxt = 1'b0;
    re_nxt = 1'b0;
    fifo_pop = 1'b0;
    unique case (st_r)
      ELA_ST_IDLE: begin
        if (fifo_valid && endok_r) begin
          if (illegal) begin
            fifo_pop = 1'b1;
            rv_nxt = 1'b1;
            re_nxt = 1'b1;
            rdata_nxt = '0;
          end else begin
            k_nxt = ELA_CYCLE_FIRST;
            acc_nxt = '0;
            st_nxt = ELA_ST_DRIVE;
          end
        end
      end
      ELA_ST_DRIVE: begin
        bus_nxt = bus_drv;
        if (ack_hi && bus_r.cycle) begin
          for (int l = 0; l < ELA_LANES; l++) begin
            if (lane_use[l] && !hd.write) begin // RQ13
              acc_nxt[8*lane_sel[l] +: 8] = din_s3_r[8*l +: 8];
            end
          end
          bus_nxt = ELA_BUS_IDLE;
          st_nxt = ELA_ST_RELEASE;
        end
      end
      ELA_ST_RELEASE: begin
        if (ack_lo) begin
          if (k_r == ncyc_m1) begin
            fifo_pop = 1'b1;
            rv_nxt = 1'b1;
            rdata_nxt = acc_r;
            st_nxt = ELA_ST_IDLE;
          end else begin
            k_nxt = k_r + 2'h1; // RQ6
            st_nxt = ELA_ST_DRIVE;
          end
        end
      end
      default: begin
        bus_nxt = ELA_BUS_IDLE;
        st_nxt = ELA_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_r <= ELA_ST_IDLE;
      bus_r <= ELA_BUS_IDLE;
      k_r <= ELA_CYCLE_FIRST;
      acc_r <= '0;
      rdata_r <= '0;
      rv_r <= 1'b0;
      re_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      bus_r <= bus_nxt;
      k_r <= k_nxt;
      acc_r <= acc_nxt;
      rdata_r <= rdata_nxt;
      rv_r <= rv_nxt;
      re_r <= re_nxt;
    end
  end

  assign o_rsp_valid = rv_r;
  assign o_rsp_error = re_r;
  assign o_rsp_rdata = rdata_r;
  assign o_little_endian = le_r;
  assign o_endian_ready = endok_r;
  assign o_bus_cycle = bus_r.cycle;
  assign o_bus_write = bus_r.write;
  assign o_bus_addr = bus_r.addr;
  assign o_lane_write_strobe = bus_r.write_strobe;
  assign o_lane_byte_mask = bus_r.byte_mask;
  assign o_data_out = bus_r.data;
  assign o_data_oe = bus_r.data_oe;
endmodule

// file: ela_chk.sv
// Bus-side checks for the lane alignment block.
// Assumes binding to ela_lane_align.
`timescale 1ns/100ps
module ela_chk (
  input wire logic i_mclk, // Clock
  input wire logic i_nrst, // Reset
  input wire logic i_bus_ack, // Ack
  input wire logic o_rsp_valid, // Done
  input wire logic o_rsp_error, // Error
  input wire logic o_little_endian, // Order
  input wire logic o_endian_ready, // Order caught
  input wire logic o_bus_cycle, // Cycle
  input wire logic o_bus_write, // Write
  input wire logic [1:0] o_bus_addr, // Offset
  input wire logic [3:0] o_lane_write_strobe, // Strobes
  input wire logic [3:0] o_lane_byte_mask, // Masks
  input wire logic [3:0] o_data_oe // Enables
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_nrst);
  a_idle_quiet: assert property (
    !o_bus_cycle |-> o_lane_write_strobe == 4'h0 && o_lane_byte_mask == 4'hf)
    else $error("lane active while idle");
  a_read_quiet: assert property (
    o_bus_cycle && !o_bus_write |-> o_lane_write_strobe == 4'h0 &&
    o_data_oe == 4'h0) else $error("read drives lanes");
  a_oe_lanes: assert property (
    o_bus_cycle && o_bus_write |-> o_data_oe != 4'h0 &&
    o_data_oe == (o_lane_write_strobe | ~o_lane_byte_mask))
    else $error("enables differ from lanes");
  a_strobe_mask: assert property (
    o_bus_cycle |-> (o_lane_write_strobe & ~o_lane_byte_mask) == 4'h0)
    else $error("strobe and mask together");
  a_early_cycle: assert property (
    !o_endian_ready |-> !o_bus_cycle) else $error("cycle before order");
  a_order_frozen: assert property (
    o_endian_ready |=> o_endian_ready && $stable(o_little_endian))
    else $error("order changed");
  a_cycle_hold: assert property (
    o_bus_cycle && !i_bus_ack |=> o_bus_cycle && $stable(o_bus_addr) &&
    $stable(o_lane_write_strobe)) else $error("cycle not held");
  a_ack_release: assert property (
    o_bus_cycle && $rose(i_bus_ack) |-> o_bus_cycle [*2] ##[1:4]
    !o_bus_cycle) else $error("cycle end late");
  a_err_valid: assert property (
    o_rsp_error |-> o_rsp_valid) else $error("error without done");
endmodule
bind ela_lane_align ela_chk u_chk (.i_mclk, .i_nrst, .i_bus_ack,
  .o_rsp_valid, .o_rsp_error, .o_little_endian, .o_endian_ready,
  .o_bus_cycle, .o_bus_write, .o_bus_addr, .o_lane_write_strobe,
  .o_lane_byte_mask, .o_data_oe);

// file: ela_dev.sv
// Behavioural external device answering each bus cycle.
// Assumes the four-phase ack handshake.
`timescale 1ns/100ps
module ela_dev (
  input wire logic i_mclk, // Clock
  input wire logic i_cycle, // Cycle
  input wire logic [1:0] i_addr, // Offset
  input wire logic [7:0] i_wait, // Ack delay
  output logic o_ack = 1'b0, // Ack
  output logic [31:0] o_data = 32'h0 // Read data
);
  logic [7:0] cnt = 8'h0;
  always @(posedge i_mclk) begin
    if (i_cycle && !o_ack) begin
      cnt <= cnt + 8'h1;
      if (cnt >= i_wait) begin
        o_ack <= 1'b1;
        o_data <= 32'h40302010 + {4{6'h0, i_addr}};
        cnt <= 8'h0;
      end
    end else if (!i_cycle && o_ack) begin
      o_ack <= 1'b0;
      o_data <= ~o_data; // Released bus keeps no value
    end
  end
endmodule

// file: ela_lane_align_tb.sv
// Self-checking bench for the lane alignment block.
// Assumes ela_dev as the far-side device.
`timescale 1ns/100ps
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("Error %s expected %h seen %h", n, e, g); end end
module ela_lane_align_tb;
  import ela_pkg::*;
  logic i_mclk = 1'b0;
  logic i_nrst = 1'b0;
  logic rv = 1'b0;
  logic pin = 1'b0;
  logic cd = 1'b0;
  ela_req_s rq = '0;
  ela_area_e ar = ELA_AREA_NORMAL;
  logic [7:0] wt = 8'h0;
  logic rdy, vld, err, cyc, bw, ack, lit, erdy;
  logic [1:0] ba, a0, al;
  logic w0;
  logic [3:0] ws, bm, oe;
  logic [31:0] rdat, dout, din;
  logic [3:0] rl [8];
  logic [31:0] rd [8];
  int nc = 0;
  int n_errors = 0;
  int n_checks = 0;
  always #20 i_mclk = ~i_mclk;
  ela_lane_align dut (.i_mclk(i_mclk), .i_nrst(i_nrst), .i_req_valid(rv),
    .i_req(rq), .o_req_ready(rdy), .o_rsp_valid(vld), .o_rsp_error(err),
    .o_rsp_rdata(rdat), .i_endian_select_pin(pin), .o_little_endian(lit),
    .o_endian_ready(erdy), .o_bus_cycle(cyc), .o_bus_write(bw),
    .o_bus_addr(ba), .o_lane_write_strobe(ws), .o_lane_byte_mask(bm),
    .o_data_out(dout), .o_data_oe(oe), .i_data_in(din), .i_bus_ack(ack));
  ela_dev dev (.i_mclk(i_mclk), .i_cycle(cyc), .i_addr(ba), .i_wait(wt),
    .o_ack(ack), .o_data(din));
  always @(posedge i_mclk) begin
    cd <= cyc;
    if (cyc && !cd) begin
      if (nc == 0) begin
        a0 = ba;
        w0 = bw;
      end
      al = ba;
      rl[nc[2:0]] = ws | ~bm;
      rd[nc[2:0]] = dout & {{8{oe[3]}}, {8{oe[2]}}, {8{oe[1]}}, {8{oe[0]}}};
      nc++;
    end
  end
  task give_verdict;
    $display("errors %0d checks %0d", n_errors, n_checks);
    if (n_errors == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task rst(input logic p);
    @(negedge i_mclk);
    pin = p;
    i_nrst = 1'b0;
    repeat (16) @(negedge i_mclk);
    i_nrst = 1'b1;
    repeat (8) @(negedge i_mclk);
    `CHK("ready", 1'b1, erdy)
    `CHK("order", p, lit)
    pin = ~p;
  endtask
  task run(input logic w, input logic [1:0] s, input logic [1:0] d,
    input logic [1:0] a, input logic [31:0] v, input logic e, input int n,
    input logic [3:0] l, input logic [31:0] x);
    int k;
    @(negedge i_mclk);
    nc = 0;
    rv = 1'b1;
    rq = '{w, s, d, ar, a, v};
    while (rdy !== 1'b1) @(negedge i_mclk);
    @(negedge i_mclk);
    rv = 1'b0;
    k = 0;
    do begin
      @(posedge i_mclk);
      #1;
      k++;
    end while (vld !== 1'b1 && k < 400);
    `CHK("done", 1'b1, vld)
    `CHK("error", e, err)
    if (n > 0) `CHK("write", w, w0)
    if (n > 0) `CHK("step", 2'((n - 1) << d), 2'(al - a0))
    `CHK("cycles", n, nc)
    if (n > 0) `CHK("lanes", l, rl[0])
    if (!e) `CHK("value", x, w ? rd[nc - 1] : rdat)
  endtask
  task t_big32;
    for (int a = 0; a < 4; a++)
      run(1, 0, 2, a, 'h5a, 0, 1, 4'h8 >> a, 'h5a << (8 * (3 - a)));
    run(1, 1, 2, 0, 'hbeef, 0, 1, 4'hc, 'hbeef0000);
    run(1, 1, 2, 2, 'hbeef, 0, 1, 4'h3, 'hbeef);
    run(1, 2, 2, 0, 'h11223344, 0, 1, 4'hf, 'h11223344);
    run(0, 0, 2, 1, 0, 0, 1, 0, 'h30);
    run(0, 2, 2, 0, 0, 0, 1, 0, 'h40302010);
  endtask
  task t_big16;
    for (int a = 0; a < 4; a++)
      run(1, 0, 1, a, 'h5a, 0, 1, a % 2 ? 1 : 2, 'h5a << (a % 2 ? 0 : 8));
    run(1, 2, 1, 0, 'h11223344, 0, 2, 4'h3, 'h3344);
    run(0, 2, 1, 0, 0, 0, 2, 0, 'h20102212);
  endtask
  task t_big8;
    for (int a = 0; a < 4; a++)
      run(1, 0, 0, a, 'h5a, 0, 1, 4'h1, 'h5a);
    run(1, 1, 0, 2, 'hbeef, 0, 2, 4'h1, 'hef);
    run(0, 2, 0, 0, 0, 0, 4, 0, 'h10111213);
  endtask
  task t_areas;
    run(1, 0, 3, 0, 'h5a, 1, 0, 0, 0);
    ar = ELA_AREA_SDRAM;
    run(1, 0, 0, 0, 'h5a, 1, 0, 0, 0);
    run(1, 0, 1, 1, 'h5a, 0, 1, 4'h1, 'h5a);
    run(0, 1, 2, 0, 0, 0, 1, 4'hc, 'h4030);
    ar = ELA_AREA_PCMCIA;
    run(1, 0, 2, 0, 'h5a, 1, 0, 0, 0);
    run(0, 2, 0, 0, 0, 0, 4, 0, 'h10111213);
    ar = ela_area_e'(2'h3);
    run(1, 0, 2, 0, 'h5a, 1, 0, 0, 0);
    ar = ELA_AREA_NORMAL;
    run(1, 1, 2, 1, 'h5a, 1, 0, 0, 0);
    run(0, 3, 2, 0, 0, 1, 0, 0, 0);
  endtask
  task t_fifo;
    int p;
    int k;
    p = 0;
    k = 0;
    wt = 8'd30;
    @(negedge i_mclk);
    rq = '{1'b1, 2'h0, 2'h2, ar, 2'h0, 32'h5a};
    rv = 1'b1;
    while (rdy === 1'b1 && p < 12) begin
      @(negedge i_mclk);
      p++;
    end
    rv = 1'b0;
    `CHK("full", 1'b1, p == 8 || p == 9)
    while (p > 0 && k < 3000) begin
      @(posedge i_mclk);
      #1;
      if (vld === 1'b1) p--;
      k++;
    end
    `CHK("drained", 0, p)
    wt = 8'h0;
  endtask
  task t_little;
    run(1, 0, 2, 0, 'h5a, 0, 1, 4'h1, 'h5a);
    run(0, 2, 1, 0, 0, 0, 2, 0, 'h22122010);
    run(0, 2, 0, 0, 0, 0, 4, 0, 'h13121110);
  endtask
  initial begin
    repeat (20000) @(posedge i_mclk);
    n_errors++;
    give_verdict;
  end
  initial begin
    rst(1'b0);
    t_big32;
    t_big16;
    t_big8;
    t_areas;
    t_fifo;
    rst(1'b1);
    t_little;
    give_verdict;
  end
endmodule
